// ===== hdl/smc_clk_gate.v
// registered clock-enable outputs per peripheral group
`timescale 1ns/1ps

module smc_clk_gate (
	input wire sys_clk, // system clock
	input wire rstn, // async reset, active low
	input wire cpuHalt, // cpu-halt mode active
	input wire tbOnly, // time-base-only mode active
	output reg cpuRun, // cpu clock enable
	output reg wdogRun, // watchdog clock enable
	output reg periphRun, // peripheral clock enable
	output reg tbRun // time base timer clock enable
);

	// time base keeps running in every mode; peripherals stop only in tb-only
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cpuRun <= 1'b1;
			wdogRun <= 1'b1;
			periphRun <= 1'b1;
			tbRun <= 1'b1;
		end else begin
			cpuRun <= ~(cpuHalt | tbOnly);
			wdogRun <= ~(cpuHalt | tbOnly);
			periphRun <= ~tbOnly;
			tbRun <= 1'b1;
		end
	end

endmodule // smc_clk_gate

// ===== hdl/smc_edge_sync.v
// three-stage synchroniser with falling edge detection for the time base source clock
`timescale 1ns/1ps

module smc_edge_sync (
	input wire sys_clk, // system clock
	input wire rstn, // async reset, active low
	input wire asyncIn, // level from another clock
	output reg fallPulse // one-cycle pulse on a falling edge
);

	reg s1_q;
	reg s2_q;
	reg s3_q;
	reg lvl_q;

	// stage one feeds stage two only; the level moves once stages two and three agree
	// so one late sample on a slow source cannot fake an edge
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
			fallPulse <= 1'b0;
		end else begin
			s1_q <= asyncIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				lvl_q <= s3_q;
			fallPulse <= lvl_q & ~s2_q & ~s3_q;
		end
	end

endmodule // smc_edge_sync

// ===== hdl/smc_standby_ctrl.v
// standby mode controller: halt, time-base-only and slow run switching with AXI4-Lite registers
//
// Summary of operation
// - software disables master irq, enables wake sources, then writes halt bit.
// - master irq enable picks plain release (0) or serviced release (1).
// - halt release clears halt bit, returns to previous run mode.
// - reset releases any standby mode; restart in fast single-clock run.
// - plain release: any enabled pending source wakes, no service, resume next.
// - serviced release: enabled irq wakes and its service routine runs.
// - watchdog irq just before entry: service it, do not enter standby.
// - cpu-halt stops cpu and watchdog, peripherals keep running.
// - time-base-only gates every peripheral clock except the time base.
// - memory, registers and port latches hold during time-base-only.
// - program counter holds start address plus 2 during time-base-only.
// - writing 1 to peripheral clock gate bit enters time-base-only.
// - tb-only release kind is AND of master, tb irq and tb enables.
// - tb-only release clears gate bit, returns to previous run mode.
// - time base enabled at tb-only start sets the time base irq latch.
// - plain tb release on falling edge of selected source, resume next.
// - serviced tb release on that edge starts time base irq service.
// - tb-only exit is asynchronous, stay may be shorter than a period.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "smc_map.vh"

module smc_standby_ctrl (
	input wire sys_clk, // system clock, 40 MHz
	input wire rstn, // async reset pin, active low
	input wire [31:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write strobes
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [31:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire [7:0] irqPending, // pending latches from the interrupt unit
	input wire wdogIrq, // watchdog interrupt request
	input wire [7:0] tbSrcClks, // candidate time base source clocks
	input wire [15:0] haltPc, // address of the standby start instruction
	output reg irqServiceReq, // pulse: wake with interrupt service
	output reg resumeNext, // pulse: wake, resume at next instruction
	output reg tbLatchSet, // pulse: set the time base irq latch
	output reg wdogServiceReq, // pulse: service watchdog, entry refused
	output reg [15:0] pcHold, // program counter held in standby
	output reg stateFreeze, // memory, registers, port latches hold
	output reg cpuClkEn, // cpu clock enable
	output reg wdogClkEn, // watchdog clock enable
	output reg periphClkEn, // peripheral clock enable
	output reg tbClkEn, // time base clock enable
	output reg fastOscEn, // fast oscillator enable
	output reg slowOscEn, // low-frequency oscillator enable
	output reg mainClkSel, // 1 selects low-frequency main clock
	output reg [1:0] runMode // current run mode code
);

	// ***********************************
	// state
	// ***********************************
	localparam ST_RUN = 2'h0;
	localparam ST_HALT = 2'h1;
	localparam ST_TBONLY = 2'h2;

	reg [1:0] st_q;
	reg [7:0] sysctl2_q;
	reg [7:0] tbctl_q;
	reg masterIe_q;
	reg tbIe_q;
	reg [7:0] wakeEn_q;
	reg servedRelease_q;
	reg [1:0] prevMode_q;
	reg [31:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg awHave_q;
	reg wHave_q;
	wire tbFall;
	wire cpuHaltW;
	wire tbOnlyW;
	wire cpuRunW;
	wire wdogRunW;
	wire periphRunW;
	wire tbRunW;
	wire [7:0] fallVec;
	reg [1:0] modeNow;
	reg wrHit;
	reg [3:0] wrOfs;
	reg wrOk;

	// ***********************************
	// time base source edges
	// ***********************************
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : gTbSync
			smc_edge_sync uSync (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.asyncIn(tbSrcClks[gi]),
				.fallPulse(fallVec[gi])
			);
		end
	endgenerate

	// only the rate-selected source can wake the tb-only mode
	assign tbFall = fallVec[tbctl_q[`SMC_TBRATE_LSB +: `SMC_RATE_W]];

	// ***********************************
	// clock gating
	// ***********************************
	assign cpuHaltW = (st_q == ST_HALT);
	assign tbOnlyW = (st_q == ST_TBONLY);

	smc_clk_gate uGate (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.cpuHalt(cpuHaltW),
		.tbOnly(tbOnlyW),
		.cpuRun(cpuRunW),
		.wdogRun(wdogRunW),
		.periphRun(periphRunW),
		.tbRun(tbRunW)
	);

	// ***********************************
	// run mode decode
	// ***********************************
	// fast osc off with slow clock chosen is the slow single-osc mode
	// decoded from the control bits only: real oscillator settling is not seen here
	always @* begin
		if (!sysctl2_q[`SMC_CLK_SEL_BIT] && !sysctl2_q[`SMC_SOSC_EN_BIT])
			modeNow = `SMC_MODE_FAST1;
		else if (!sysctl2_q[`SMC_CLK_SEL_BIT])
			modeNow = `SMC_MODE_FAST2;
		else if (sysctl2_q[`SMC_FOSC_EN_BIT])
			modeNow = `SMC_MODE_SLOW_RUN_FAST_OSC_ON;
		else
			modeNow = `SMC_MODE_SLOW_RUN_FAST_OSC_OFF;
	end

	// ***********************************
	// AXI4-Lite write path
	// ***********************************
	// address and data may come in either order; one write in flight
	always @* begin
		wrHit = awHave_q & wHave_q & ~s_axi_bvalid;
		wrOfs = awaddr_q[3:0];
		// only the three writable words answer okay; status and holes give an error
		wrOk = (awaddr_q[31:4] == 28'h0) &&
			(wrOfs == `SMC_SYSCTL2_OFS || wrOfs == `SMC_TBCTL_OFS || wrOfs == `SMC_IRQCTL_OFS);
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awaddr_q <= 32'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			s_axi_awready <= ~awHave_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~wHave_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wrHit) begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// refused writes still get a response so the master never stalls
				s_axi_bresp <= wrOk ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ***********************************
	// AXI4-Lite read path
	// ***********************************
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				// outside the 16-byte window reads zero with an error, never an alias
				if (s_axi_araddr[31:4] != 28'h0) begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end else begin
					case (s_axi_araddr[3:0])
						`SMC_SYSCTL2_OFS: s_axi_rdata <= {24'h0, sysctl2_q};
						`SMC_TBCTL_OFS: s_axi_rdata <= {24'h0, tbctl_q};
						`SMC_IRQCTL_OFS: s_axi_rdata <= {wakeEn_q, 22'h0, tbIe_q, masterIe_q};
						`SMC_STATUS_OFS: s_axi_rdata <= {26'h0, prevMode_q, runMode, st_q};
						default: begin
							s_axi_rdata <= 32'h0;
							s_axi_rresp <= 2'h2;
						end
					endcase
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ***********************************
	// mode control
	// ***********************************
	// hardware clear of the request bits on wake wins over a concurrent write
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_RUN;
			sysctl2_q <= `SMC_SYSCTL2_RST;
			tbctl_q <= `SMC_TBCTL_RST;
			masterIe_q <= 1'b0;
			tbIe_q <= 1'b0;
			wakeEn_q <= 8'h00;
			servedRelease_q <= 1'b0;
			prevMode_q <= `SMC_MODE_FAST1;
			irqServiceReq <= 1'b0;
			resumeNext <= 1'b0;
			tbLatchSet <= 1'b0;
			wdogServiceReq <= 1'b0;
		end else begin
			irqServiceReq <= 1'b0;
			resumeNext <= 1'b0;
			tbLatchSet <= 1'b0;
			wdogServiceReq <= 1'b0;
			if (wrHit && awaddr_q[31:4] == 28'h0 && wstrb_q[0]) begin
				case (wrOfs)
					`SMC_SYSCTL2_OFS: sysctl2_q <= wdata_q[7:0];
					`SMC_TBCTL_OFS: tbctl_q <= wdata_q[7:0];
					`SMC_IRQCTL_OFS: begin
						masterIe_q <= wdata_q[`SMC_MIE_BIT];
						tbIe_q <= wdata_q[`SMC_TBIE_BIT];
						if (wstrb_q[3])
							wakeEn_q <= wdata_q[31:24];
					end
					default: ;
				endcase
			end
			case (st_q)
				ST_RUN: begin
					if (sysctl2_q[`SMC_HALT_BIT] || sysctl2_q[`SMC_GATE_BIT]) begin
						prevMode_q <= modeNow;
						if (wdogIrq) begin
							// entry refused; request bits dropped
							wdogServiceReq <= 1'b1;
							sysctl2_q[`SMC_HALT_BIT] <= 1'b0;
							sysctl2_q[`SMC_GATE_BIT] <= 1'b0;
						end else if (sysctl2_q[`SMC_GATE_BIT]) begin
							st_q <= ST_TBONLY;
							// release kind latched now; enable writes in standby leave it alone
							servedRelease_q <= masterIe_q & tbIe_q & tbctl_q[`SMC_TBEN_BIT];
							tbLatchSet <= tbctl_q[`SMC_TBEN_BIT];
						end else begin
							st_q <= ST_HALT;
							servedRelease_q <= masterIe_q;
						end
					end
				end
				ST_HALT: begin
					if (|(irqPending & wakeEn_q)) begin
						st_q <= ST_RUN;
						sysctl2_q[`SMC_HALT_BIT] <= 1'b0;
						irqServiceReq <= servedRelease_q;
						resumeNext <= ~servedRelease_q;
					end
				end
				ST_TBONLY: begin
					if (tbFall) begin
						st_q <= ST_RUN;
						sysctl2_q[`SMC_GATE_BIT] <= 1'b0;
						irqServiceReq <= servedRelease_q;
						resumeNext <= ~servedRelease_q;
					end
				end
				default: st_q <= ST_RUN;
			endcase
		end
	end

	// ***********************************
	// registered outputs
	// ***********************************
	// run mode held at the pre-standby value in standby, decoded from the control bits again once run resumes
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pcHold <= 16'h0000;
			stateFreeze <= 1'b0;
			cpuClkEn <= 1'b1;
			wdogClkEn <= 1'b1;
			periphClkEn <= 1'b1;
			tbClkEn <= 1'b1;
			fastOscEn <= 1'b1;
			slowOscEn <= 1'b0;
			mainClkSel <= 1'b0;
			runMode <= `SMC_MODE_FAST1;
		end else begin
			if (st_q == ST_RUN)
				pcHold <= haltPc + 16'h0002;
			stateFreeze <= (st_q != ST_RUN);
			cpuClkEn <= cpuRunW;
			wdogClkEn <= wdogRunW;
			periphClkEn <= periphRunW;
			tbClkEn <= tbRunW;
			// oscillator pins copy the bits; software owns the order of the steps
			fastOscEn <= sysctl2_q[`SMC_FOSC_EN_BIT];
			slowOscEn <= sysctl2_q[`SMC_SOSC_EN_BIT];
			mainClkSel <= sysctl2_q[`SMC_CLK_SEL_BIT];
			runMode <= (st_q == ST_RUN) ? modeNow : prevMode_q;
		end
	end

endmodule // smc_standby_ctrl

// ===== inc/smc_map.vh
// register offsets, field positions, reset values and field widths of the standby controller
`ifndef SMC_MAP_VH
`define SMC_MAP_VH

// ***********************************
// register byte offsets
// ***********************************
`define SMC_SYSCTL2_OFS 4'h0
`define SMC_TBCTL_OFS 4'h4
`define SMC_IRQCTL_OFS 4'h8
`define SMC_STATUS_OFS 4'hc

// ***********************************
// system_control_2 fields
// ***********************************
`define SMC_FOSC_EN_BIT 7
`define SMC_SOSC_EN_BIT 6
`define SMC_CLK_SEL_BIT 5
`define SMC_GATE_BIT 4
`define SMC_HALT_BIT 3
`define SMC_SYSCTL2_RST 8'h80

// ***********************************
// time_base_control fields
// ***********************************
`define SMC_TBEN_BIT 3
`define SMC_TBRATE_LSB 0
`define SMC_TBCTL_RST 8'h00

// ***********************************
// irq control fields
// ***********************************
`define SMC_MIE_BIT 0
`define SMC_TBIE_BIT 1

// ***********************************
// run modes and field widths
// ***********************************
`define SMC_MODE_FAST1 2'h0
`define SMC_MODE_FAST2 2'h1
`define SMC_MODE_SLOW_RUN_FAST_OSC_OFF 2'h2
`define SMC_MODE_SLOW_RUN_FAST_OSC_ON 2'h3
`define SMC_RATE_W 3
`define SMC_IRQ_W 8

`endif

// ===== test/smc_core_model.sv
// behavioural core, interrupt latches and time base source clocks
`timescale 1ns/1ps

module smc_core_model #(
	parameter [15:0] PC0 = 16'h0100 // start address, arbitrary
) (
	input wire sys_clk, // clock
	input wire rstn, // reset, active low
	input wire [7:0] raise, // bench sets latches
	input wire [7:0] clr, // software clears latches
	input wire tbLatchSet, // time base latch set
	input wire resumeNext, // plain wake
	input wire irqServiceReq, // serviced wake
	output reg [7:0] irqPending, // pending latches
	output wire [7:0] tbSrcClks, // source clocks
	output reg [15:0] haltPc // standby start address
);
	reg [9:0] divCnt_q;

	// free divider; source n has a period of 2^(n+2) cycles
	assign tbSrcClks = divCnt_q[8:1];

	// latches hold until software loads 0; code moves on after each wake
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irqPending <= 8'h00;
			divCnt_q <= 10'h000;
			haltPc <= PC0;
		end else begin
			divCnt_q <= divCnt_q + 10'h001;
			irqPending <= (irqPending | raise | {tbLatchSet, 7'h00}) & ~clr;
			if (resumeNext || irqServiceReq) haltPc <= haltPc + 16'h0004;
		end
	end
endmodule // smc_core_model

// ===== test/smc_standby_ctrl_tb.sv
// testbench of the standby controller: register traffic, standby entry and release
`timescale 1ns/1ps
`include "smc_map.vh"

module smc_standby_ctrl_tb;
	reg sys_clk = 1'b0;
	reg rstn = 1'b0;
	reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, wdogIrq = 1'b0;
	reg [7:0] raise = 8'h0, clr = 8'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, runMode;
	wire [31:0] s_axi_rdata;
	wire [7:0] irqPending, tbSrcClks;
	wire [15:0] haltPc, pcHold;
	wire irqServiceReq, resumeNext, tbLatchSet, wdogServiceReq, stateFreeze;
	wire cpuClkEn, wdogClkEn, periphClkEn, tbClkEn, fastOscEn, slowOscEn, mainClkSel;
	integer n_fail = 0, n_checks = 0, i;
	reg [31:0] got;
	reg [1:0] resp;
	reg [15:0] cases [0:2];

	always #12.5 sys_clk = ~sys_clk;

	smc_standby_ctrl dut_u (.*);
	smc_core_model core_u (.*);

	// ***********************************
	// bus and compare tasks
	// ***********************************
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		integer k;
		begin
			@(posedge sys_clk);
			s_axi_awaddr <= {24'h0, a};
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			k = 0;
			resp = 2'h3;
			while (resp == 2'h3 && k < 100) begin
				@(posedge sys_clk);
				k = k + 1;
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid) begin
					resp = s_axi_bresp;
					s_axi_bready <= 1'b0;
				end
			end
			chk(resp, er);
		end
	endtask

	task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
		integer k;
		reg g;
		begin
			@(posedge sys_clk);
			s_axi_araddr <= {24'h0, a};
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			k = 0;
			g = 1'b0;
			got = 32'hx;
			resp = 2'hx;
			while (!g && k < 100) begin
				@(posedge sys_clk);
				k = k + 1;
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid) begin
					g = 1'b1;
					got = s_axi_rdata;
					resp = s_axi_rresp;
					s_axi_rready <= 1'b0;
				end
			end
			chk(got, exp);
			chk(resp, er);
		end
	endtask

	// pulses stand one cycle, so look at every falling edge
	task waitHi(input [1:0] s);
		integer k;
		reg [3:0] p;
		begin
			k = 0;
			p = 4'h0;
			while (p[s] !== 1'b1 && k < 700) begin
				@(negedge sys_clk);
				p = {wdogServiceReq, tbLatchSet, irqServiceReq, resumeNext};
				k = k + 1;
			end
			chk(p[s], 1'b1);
		end
	endtask

	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_fail);
			if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask

	// ***********************************
	// test sequence
	// ***********************************
	initial begin
		cases[0] = 16'h0f00;
		cases[1] = 16'h0f31;
		cases[2] = 16'h0730;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(8'h0, 32'h80, 2'h0);
		rd(8'hc, 32'h0, 2'h0);
		rd(8'h10, 32'h0, 2'h2);
		wr(8'hc, 32'h1, 2'h2);
		$display("test reset done");
		// plain release first, then serviced release
		for (i = 0; i < 2; i = i + 1) begin
			wr(8'h8, 32'h01000000 | i, 2'h0);
			wr(8'h0, 32'h88, 2'h0);
			repeat (3) @(negedge sys_clk);
			chk({cpuClkEn, wdogClkEn, periphClkEn, stateFreeze}, 4'h3);
			@(posedge sys_clk) raise <= 8'h01;
			@(posedge sys_clk) raise <= 8'h00;
			waitHi(i[1:0]);
			rd(8'h0, 32'h80, 2'h0);
			@(posedge sys_clk) clr <= 8'hff;
			@(posedge sys_clk) clr <= 8'h00;
		end
		@(posedge sys_clk) wdogIrq <= 1'b1;
		wr(8'h0, 32'h88, 2'h0);
		waitHi(2'h3);
		rd(8'h0, 32'h80, 2'h0);
		@(posedge sys_clk) wdogIrq <= 1'b0;
		$display("test halt done");
		// enter just after a source fall so the check lands before the wake
		for (i = 0; i < 3; i = i + 1) begin
			while (tbSrcClks[7] !== 1'b1) @(negedge sys_clk);
			while (tbSrcClks[7] !== 1'b0) @(negedge sys_clk);
			wr(8'h4, cases[i][15:8], 2'h0);
			wr(8'h8, cases[i][7:4], 2'h0);
			wr(8'h0, 32'h90, 2'h0);
			if (cases[i][11]) begin
				waitHi(2'h2);
			end else begin
				@(negedge sys_clk);
				chk(tbLatchSet, 1'b0);
			end
			repeat (2) @(negedge sys_clk);
			chk({periphClkEn, tbClkEn, stateFreeze}, 3'h3);
			chk(pcHold, haltPc + 16'h2);
			waitHi(cases[i][1:0]);
			rd(8'h0, 32'h80, 2'h0);
			@(posedge sys_clk) clr <= 8'hff;
			@(posedge sys_clk) clr <= 8'h00;
		end
		$display("test time base done");
		wr(8'h0, 32'hc0, 2'h0);
		repeat (2) @(negedge sys_clk);
		chk({slowOscEn, runMode}, {1'b1, `SMC_MODE_FAST2});
		wr(8'h0, 32'he0, 2'h0);
		repeat (2) @(negedge sys_clk);
		chk({mainClkSel, runMode}, {1'b1, `SMC_MODE_SLOW_RUN_FAST_OSC_ON});
		wr(8'h0, 32'h60, 2'h0);
		repeat (2) @(negedge sys_clk);
		chk({fastOscEn, runMode}, {1'b0, `SMC_MODE_SLOW_RUN_FAST_OSC_OFF});
		wr(8'h8, 32'h01000000, 2'h0);
		wr(8'h0, 32'h68, 2'h0);
		rd(8'hc, 32'h29, 2'h0);
		@(posedge sys_clk) raise <= 8'h01;
		@(posedge sys_clk) raise <= 8'h00;
		waitHi(2'h0);
		chk(runMode, `SMC_MODE_SLOW_RUN_FAST_OSC_OFF);
		@(posedge sys_clk) clr <= 8'hff;
		@(posedge sys_clk) clr <= 8'h00;
		wr(8'h0, 32'h68, 2'h0);
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		chk({runMode, stateFreeze, fastOscEn}, 4'h1);
		rd(8'h0, 32'h80, 2'h0);
		$display("test slow done");
		close_out;
	end

	// hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#500000;
		n_fail = n_fail + 1;
		$display("BAD %0t timeout", $time);
		close_out;
	end
endmodule // smc_standby_ctrl_tb

// ===== test/smc_standby_monitor.sv
// concurrent checks on the standby controller ports
`timescale 1ns/1ps
`include "smc_map.vh"

module smc_standby_monitor (
	input logic sys_clk, // clock
	input logic rstn, // reset, active low
	input logic resumeNext, // plain wake
	input logic irqServiceReq, // serviced wake
	input logic tbLatchSet, // latch set pulse
	input logic wdogServiceReq, // refused entry
	input logic stateFreeze, // in standby
	input logic cpuClkEn, // cpu clock
	input logic wdogClkEn, // watchdog clock
	input logic periphClkEn, // peripheral clock
	input logic tbClkEn, // time base clock
	input logic [15:0] pcHold, // held pc
	input logic [1:0] runMode, // run mode
	input logic mainClkSel, // slow main clock
	input logic fastOscEn // fast osc
);
	// ***********************************
	// wake, gating and mode relations
	// ***********************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// wake pulses are single cycle and of one kind only
	a_plain_wake_pulse: assert property (resumeNext |=> !resumeNext)
		else $error("plain wake pulse too long");
	a_serviced_wake_pulse: assert property (irqServiceReq |=> !irqServiceReq)
		else $error("serviced wake pulse too long");
	a_single_wake_kind: assert property (!(resumeNext && irqServiceReq))
		else $error("both wake kinds at once");
	a_latch_set_pulse: assert property (tbLatchSet |=> !tbLatchSet)
		else $error("latch set pulse too long");
	// a refused entry must leave the core running
	a_wdog_no_entry: assert property (wdogServiceReq |-> !stateFreeze ##1 !stateFreeze)
		else $error("standby entered despite watchdog");
	// enables lag the state by a cycle, hence the short window
	a_halt_stops_cpu: assert property ($rose(stateFreeze) |-> ##[0:2] (!cpuClkEn && !wdogClkEn))
		else $error("cpu or watchdog clock still on");
	a_tb_clock_runs: assert property (tbClkEn)
		else $error("time base clock gated");
	a_periph_gate_only: assert property (!periphClkEn |-> !cpuClkEn)
		else $error("peripherals gated while cpu runs");
	a_pc_held: assert property (stateFreeze && $past(stateFreeze) |-> $stable(pcHold))
		else $error("held pc moved in standby");
	a_slow_clock_sel: assert property (runMode == `SMC_MODE_SLOW_RUN_FAST_OSC_OFF |-> mainClkSel && !fastOscEn)
		else $error("slow mode with wrong clock bits");
	a_reset_fast_run: assert property ($rose(rstn) |-> runMode == `SMC_MODE_FAST1 && fastOscEn)
		else $error("not fast single run after reset");
endmodule // smc_standby_monitor

bind smc_standby_ctrl smc_standby_monitor mon_u (.*);
